// ==== bus_partner.sv ====
// Arbiter and memory model.
module bus_partner (
    // Clock and bus unit requests
    input  wire logic        ref_clk_in,
    input  wire logic        abr_n_in,
    input  wire logic        dbr_n_in,
    // Scenario controls
    input  wire logic        slow_in,
    input  wire logic        retry_in,
    input  wire logic        bad_par_in,
    // Grants, terminations and read data
    output logic             abg_n_out,
    output logic             dbg_n_out,
    output logic             aack_n_out,
    output logic             ta_n_out,
    output logic             dretry_n_out,
    output logic [63:0]      data_out,
    output logic [7:0]       par_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [63:0] cnt = 64'h0;

    // Fresh read data every cycle.
    always_ff @(posedge ref_clk_in) begin
        cnt <= cnt + 64'h0101_0101_0101_0101;
    end
    assign abg_n_out = abr_n_in | slow_in;
    assign dbg_n_out = dbr_n_in | slow_in;
    // every phase acknowledged, data retry on command
    assign aack_n_out = 1'h0;
    assign ta_n_out = 1'h0;
    assign dretry_n_out = ~retry_in;
    assign data_out = cnt;
    // odd parity per byte, spoiled on command
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            par_out[i] = ~^cnt[8*i +: 8] ^ bad_par_in;
        end
    end
endmodule : bus_partner

// ==== bus_unit.sv ====
// Processor system bus unit.
//
// Functional notes
// R01: 32-bit address bus, 64-bit data bus, plus grouped control signals.
// R02: Transactions are address-only or address plus data.
// R03: Address tenure of one transaction may overlap another's data tenure.
// R04: Address and data bus ownership are requested and held independently.
// R05: Bus clock runs at an integer multiple of the core cycle.
// R06: Single transfers move one to eight bytes in one bus cycle.
// R07: Data moves as one single beat or exactly four burst beats.
// R08: Cache-inhibited, uncached and write-through accesses use single beats.
// R09: Sector fills and write-backs burst one whole 32-byte sector.
// R10: Address-only tenures broadcast translation and cache invalidations.
// R11: I/O controller areas redefine start and attribute signalling.
// R12: I/O transfers of 1 to 128 bytes use split request and response.
// R13: Memory start and I/O start are separate strobes.
// R14: System acknowledges each address phase and may demand its repeat.
// R15: Termination after every beat; only the final one ends the tenure.
// R16: A data retry makes the device repeat that data phase.
// R17: Request and win the address bus before any address tenure.
// R18: Request and win the data bus before driving data.
// R19: Address and data carry parity; data parity errors are reported.
// R20: Attributes give size, burst, write-through and cache-inhibit.
// R21: Arbiter may apply fairness and park a master on the bus.
// R22: Coherency follows MESI; cache and translation buffer externally controllable.
// R23: System drives reservation-set and output drive size inputs.
// R24: Active-low signals are asserted low; all others asserted high.
// R25: A data tenure never starts before its address tenure has started.
// R26: Every burst beat carries a full 64-bit word.
module bus_unit
    import bus_unit_pkg::*;
#(
    parameter int RATIO = BUS_RATIO,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    // Core request port
    input  wire logic              req_valid_in,
    input  wire cmd_t              req_cmd_in,
    input  wire logic [ADDR_W-1:0] req_addr_in,
    input  wire logic [2:0]        req_bytes_in,
    input  wire logic              req_ci_in,
    input  wire logic              req_wt_in,
    output wire logic              req_ready_out,
    // Core write data
    input  wire logic              wr_valid_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    output wire logic              wr_ready_out,
    // Core read data and completion
    output wire logic              rd_valid_out,
    output wire logic [DATA_W-1:0] rd_data_out,
    output wire logic              done_out,
    // Address arbitration
    output wire logic              abr_n_out,
    input  wire logic              abg_n_in,
    // Transfer starts
    output wire logic              memory_transfer_start_n_out,
    output wire logic              io_transfer_start_n_out,
    // Address transfer and attributes
    output wire logic [ADDR_W-1:0] addr_out,
    output wire logic [APAR_W-1:0] addr_par_out,
    output wire logic [2:0]        ttype_out,
    output wire logic [2:0]        tsize_out,
    output wire logic              tbst_n_out,
    output wire logic              wt_n_out,
    output wire logic              ci_n_out,
    // Address termination
    input  wire logic              aack_n_in,
    input  wire logic              artry_n_in,
    // Data arbitration
    output wire logic              dbr_n_out,
    input  wire logic              dbg_n_in,
    // Data transfer
    output wire logic [DATA_W-1:0] data_out,
    output wire logic              data_oe_out,
    input  wire logic [DATA_W-1:0] data_in,
    output wire logic [DPAR_W-1:0] data_par_out,
    input  wire logic [DPAR_W-1:0] data_par_in,
    output wire logic              data_par_err_n_out,
    // Data termination
    input  wire logic              ta_n_in,
    input  wire logic              dretry_n_in,
    // Processor state
    input  wire logic              rsrv_set_in,
    input  wire logic              drive_size_in,
    output wire logic              rsrv_out,
    output wire logic              drive_size_out
);

    // ------------------------------------------------------------------
    // State, FIFO and helpers
    // ------------------------------------------------------------------
    unit_st_t st_ff;
    unit_st_t nxt_st;
    logic     pop;
    logic     last_beat;
    logic     go_burst;

    fifo_if #(.W(DATA_W), .CW(CNT_W)) wf ();

    data_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .port       (wf.store)
    );

    // Core write data enters the FIFO.
    assign wf.push_valid = wr_valid_in;
    assign wf.push_data  = wr_data_in;
    assign wf.pop_ready  = pop;

    // Burst only for cacheable sector moves.
    function automatic logic burst_of(input cmd_t c, input logic ci, input logic wt);
        return ((c == CMD_FILL) || (c == CMD_CASTOUT)) && !ci && !wt;
    endfunction : burst_of

    // Commands that own a data tenure.
    function automatic logic has_data(input cmd_t c);
        return (c == CMD_READ) || (c == CMD_WRITE) || (c == CMD_FILL) || (c == CMD_CASTOUT);
    endfunction : has_data

    assign go_burst  = burst_of(req_cmd_in, req_ci_in, req_wt_in);
    assign last_beat = !st_ff.d_bst || (st_ff.beat == 2'(BURST_BEATS - 1));

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st          = st_ff;
        pop             = 1'h0;
        nxt_st.bus_en   = 1'h0;
        nxt_st.rd_valid = 1'h0;
        nxt_st.done     = 1'h0;
        nxt_st.rsrv     = rsrv_set_in;
        nxt_st.drv      = drive_size_in;

        // R05 bus clock divider
        if (st_ff.div == 4'(RATIO - 1)) begin
            nxt_st.div    = 4'h0;
            nxt_st.bus_en = 1'h1;
        end else begin
            nxt_st.div = st_ff.div + 4'h1;
        end

        // Parity error report lasts one bus cycle.
        if (st_ff.bus_en) begin
            nxt_st.dpe_n = 1'h1;
        end

        // Address tenure machine.
        unique case (st_ff.a_st)
            A_IDLE: begin
                if (req_valid_in && st_ff.req_ready) begin
                    // R17 request address bus
                    nxt_st.a_st   = A_REQ;
                    nxt_st.abr_n  = 1'h0;
                    nxt_st.tt     = req_cmd_in;
                    // R08 R09 single or sector burst
                    nxt_st.addr   = go_burst ? {req_addr_in[ADDR_W-1:SECTOR_LSB], SECTOR_ZERO}
                                             : req_addr_in;
                    // R06 R26 transfer size
                    nxt_st.tsize  = go_burst ? TSIZE_FULL : req_bytes_in;
                    // R20 transfer attributes
                    nxt_st.tbst_n = !go_burst;
                    nxt_st.ci_n   = !req_ci_in;
                    nxt_st.wt_n   = !req_wt_in;
                    nxt_st.pend_rd  = (req_cmd_in == CMD_READ) || (req_cmd_in == CMD_FILL);
                    nxt_st.pend_bst = go_burst;
                end
            end
            A_REQ: begin
                // R21 grant may already be parked here
                if (st_ff.bus_en && !abg_n_in) begin
                    nxt_st.a_st  = A_START;
                    nxt_st.abr_n = 1'h1;
                    // R19 address parity
                    nxt_st.ap    = 4'(par_bytes({32'h0000_0000, st_ff.addr}));
                    // R11 R13 separate start strobes
                    if (st_ff.tt == CMD_IO) begin
                        nxt_st.ios_n = 1'h0;
                    end else begin
                        nxt_st.mts_n = 1'h0;
                    end
                end
            end
            A_START: begin
                if (st_ff.bus_en) begin
                    nxt_st.mts_n = 1'h1;
                    nxt_st.ios_n = 1'h1;
                    nxt_st.a_st  = A_WAIT;
                end
            end
            A_WAIT: begin
                // R14 address acknowledge or retry
                if (st_ff.bus_en && !aack_n_in) begin
                    if (!artry_n_in) begin
                        nxt_st.a_st  = A_REQ;
                        nxt_st.abr_n = 1'h0;
                    end else begin
                        // R02 R10 R12 address-only tenures end here
                        nxt_st.a_st = A_IDLE;
                        nxt_st.pend = has_data(st_ff.tt);
                    end
                end
            end
        endcase

        // Data tenure machine.
        unique case (st_ff.d_st)
            D_IDLE: begin
                // R25 R03 handoff only after address acknowledge
                if (st_ff.bus_en && st_ff.pend
                    && (st_ff.pend_rd
                        || wf.count >= (st_ff.pend_bst ? CNT_W'(BURST_BEATS) : CNT_W'(1)))) begin
                    // R04 R18 independent data bus request
                    nxt_st.d_st  = D_REQ;
                    nxt_st.dbr_n = 1'h0;
                    nxt_st.pend  = 1'h0;
                    nxt_st.d_rd  = st_ff.pend_rd;
                    nxt_st.d_bst = st_ff.pend_bst;
                    nxt_st.beat  = 2'h0;
                end
            end
            D_REQ: begin
                if (st_ff.bus_en && !dbg_n_in) begin
                    nxt_st.d_st  = D_XFER;
                    nxt_st.dbr_n = 1'h1;
                    if (!st_ff.d_rd) begin
                        nxt_st.dout = wf.pop_data;
                        nxt_st.dp   = par_bytes(wf.pop_data);
                        nxt_st.doe  = 1'h1;
                        pop         = 1'h1;
                    end
                end
            end
            D_XFER: begin
                // R16 retry leaves the beat in place
                if (st_ff.bus_en && !ta_n_in && dretry_n_in) begin
                    if (st_ff.d_rd) begin
                        nxt_st.rdat     = data_in;
                        nxt_st.rd_valid = 1'h1;
                        // R19 data parity check
                        if (data_par_in != par_bytes(data_in)) begin
                            nxt_st.dpe_n = 1'h0;
                        end
                    end
                    // R07 R15 only the final beat ends the tenure
                    if (last_beat) begin
                        nxt_st.d_st = D_IDLE;
                        nxt_st.doe  = 1'h0;
                        nxt_st.done = 1'h1;
                    end else begin
                        nxt_st.beat = st_ff.beat + 2'h1;
                        if (!st_ff.d_rd) begin
                            nxt_st.dout = wf.pop_data;
                            nxt_st.dp   = par_bytes(wf.pop_data);
                            pop         = 1'h1;
                        end
                    end
                end
            end
            default: begin
                nxt_st.d_st = D_IDLE;
            end
        endcase

        // Take requests only when idle.
        nxt_st.req_ready = nxt_st.bus_en && (nxt_st.a_st == A_IDLE) && !nxt_st.pend;
    end

    // State register.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= UNIT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // R24 active-low pins idle high
    assign abr_n_out                   = st_ff.abr_n;
    assign memory_transfer_start_n_out = st_ff.mts_n;
    assign io_transfer_start_n_out     = st_ff.ios_n;
    // R01 address and data buses
    assign addr_out                    = st_ff.addr;
    assign addr_par_out                = st_ff.ap;
    assign ttype_out                   = st_ff.tt;
    assign tsize_out                   = st_ff.tsize;
    assign tbst_n_out                  = st_ff.tbst_n;
    assign wt_n_out                    = st_ff.wt_n;
    assign ci_n_out                    = st_ff.ci_n;
    assign dbr_n_out                   = st_ff.dbr_n;
    assign data_out                    = st_ff.dout;
    assign data_oe_out                 = st_ff.doe;
    assign data_par_out                = st_ff.dp;
    assign data_par_err_n_out          = st_ff.dpe_n;
    assign rd_valid_out                = st_ff.rd_valid;
    assign rd_data_out                 = st_ff.rdat;
    assign done_out                    = st_ff.done;
    assign req_ready_out               = st_ff.req_ready;
    assign wr_ready_out                = wf.push_ready;
    // R22 R23 processor state copies
    assign rsrv_out                    = st_ff.rsrv;
    assign drive_size_out              = st_ff.drv;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    // R05 enable pulse spacing
    a_bus_en_rate: assert property (st_ff.bus_en |=> !st_ff.bus_en) // R05
        else $error("bus enable pulses too close");
    // R17 start after grant
    a_start_granted: assert property (($fell(memory_transfer_start_n_out)
        || $fell(io_transfer_start_n_out)) |-> $past(!abg_n_in)) // R17
        else $error("address start without grant");
    // R18 drive after grant
    a_drive_granted: assert property ($rose(data_oe_out) |-> $past(!dbg_n_in)) // R18
        else $error("data driven without grant");
    // R13 exclusive starts
    a_start_exclusive: assert property (memory_transfer_start_n_out
        || io_transfer_start_n_out) // R13
        else $error("both start strobes asserted");
    // R09 sector burst shape
    a_burst_aligned: assert property ((!memory_transfer_start_n_out && !tbst_n_out)
        |-> (addr_out[4:0] == SECTOR_ZERO) && (tsize_out == TSIZE_FULL)) // R09
        else $error("burst not a whole aligned sector");
    // R08 single beats when bypassing the cache
    a_single_nocache: assert property ((!memory_transfer_start_n_out
        && (!ci_n_out || !wt_n_out)) |-> tbst_n_out) // R08
        else $error("burst on inhibited or write-through access");
    // R19 driven data parity
    a_data_parity: assert property (data_oe_out |-> data_par_out == par_bytes(data_out)) // R19
        else $error("wrong data parity driven");
    // R25 data handoff after address acknowledge
    a_data_after_addr: assert property ($rose(st_ff.pend)
        |-> $past(st_ff.a_st == A_WAIT) && $past(!aack_n_in)) // R25
        else $error("data tenure queued before address tenure");
    // R07 single stays one beat
    a_single_beat: assert property ((st_ff.d_st == D_XFER && !st_ff.d_bst)
        |-> st_ff.beat == 2'h0) // R07
        else $error("single transfer advanced a beat");
    // R16 retried beat repeated
    a_retry_hold: assert property ((st_ff.d_st == D_XFER && st_ff.bus_en && !dretry_n_in)
        |=> $stable(st_ff.beat) && st_ff.d_st == D_XFER) // R16
        else $error("data retry not repeated");
    // R15 final beat ends tenure
    a_last_beat_end: assert property ((st_ff.d_st == D_XFER && st_ff.bus_en && !ta_n_in
        && dretry_n_in && st_ff.d_bst && st_ff.beat == 2'h3)
        |=> st_ff.d_st == D_IDLE && done_out && !data_oe_out) // R15
        else $error("burst did not end on fourth beat");

endmodule : bus_unit

// ==== bus_unit_pkg.sv ====
// Bus unit constants and types.
package bus_unit_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int ADDR_W      = 32;
    localparam int DATA_W      = 64;
    localparam int DPAR_W      = 8;
    localparam int APAR_W      = 4;
    localparam int BUS_RATIO   = 2;
    localparam int FIFO_DEPTH  = 32;
    localparam int BURST_BEATS = 4;
    localparam int SECTOR_LSB  = 5;
    localparam int CNT_W       = 6;

    // ------------------------------------------------------------------
    // Field values
    // ------------------------------------------------------------------
    localparam logic [2:0] TSIZE_FULL  = 3'h7;
    localparam logic [4:0] SECTOR_ZERO = 5'h00;

    // Request commands.
    typedef enum logic [2:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_FILL,
        CMD_CASTOUT,
        CMD_INVAL,
        CMD_IO
    } cmd_t;

    typedef enum logic [1:0] {A_IDLE, A_REQ, A_START, A_WAIT} addr_st_t;
    typedef enum logic [1:0] {D_IDLE, D_REQ, D_XFER} data_st_t;

    // Whole state of the bus unit.
    typedef struct packed {
        addr_st_t    a_st;
        data_st_t    d_st;
        logic [3:0]  div;
        logic        bus_en;
        logic        req_ready;
        logic        abr_n;
        logic        mts_n;
        logic        ios_n;
        logic [31:0] addr;
        logic [3:0]  ap;
        cmd_t        tt;
        logic [2:0]  tsize;
        logic        tbst_n;
        logic        wt_n;
        logic        ci_n;
        logic        pend;
        logic        pend_rd;
        logic        pend_bst;
        logic        dbr_n;
        logic        d_rd;
        logic        d_bst;
        logic [1:0]  beat;
        logic [63:0] dout;
        logic [7:0]  dp;
        logic        doe;
        logic        dpe_n;
        logic [63:0] rdat;
        logic        rd_valid;
        logic        done;
        logic        rsrv;
        logic        drv;
    } unit_st_t;

    // Reset value: low-active pins negated.
    localparam unit_st_t UNIT_RST = '{
        a_st: A_IDLE, d_st: D_IDLE, tt: CMD_READ,
        abr_n: 1'h1, mts_n: 1'h1, ios_n: 1'h1, tbst_n: 1'h1,
        wt_n: 1'h1, ci_n: 1'h1, dbr_n: 1'h1, dpe_n: 1'h1,
        default: '0
    };

    // Odd parity for each byte of a 64-bit word.
    function automatic logic [7:0] par_bytes(input logic [63:0] w);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            p[i] = ~^w[8*i +: 8];
        end
        return p;
    endfunction : par_bytes

endpackage : bus_unit_pkg

// ==== data_fifo.sv ====
// Write-data FIFO.
module data_fifo
    import bus_unit_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Both sides
    fifo_if.store    port
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic          in_rdy;
    } fifo_st_t;

    fifo_st_t         st_ff;
    fifo_st_t         nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // Handshakes on both sides; depth must be a power of two.
    assign push            = port.push_valid && st_ff.in_rdy;
    assign pop             = port.pop_ready && (st_ff.cnt != '0);
    assign port.push_ready = st_ff.in_rdy;
    assign port.pop_valid  = (st_ff.cnt != '0);
    assign port.pop_data   = mem[st_ff.rp];
    assign port.count      = st_ff.cnt;

    // Pointer and count update.
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wp = st_ff.wp + AW'(1);
        end
        if (pop) begin
            nxt_st.rp = st_ff.rp + AW'(1);
        end
        nxt_st.cnt    = st_ff.cnt + CW'(push) - CW'(pop);
        nxt_st.in_rdy = (nxt_st.cnt < CW'(DEPTH));
    end

    // State register.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '{in_rdy: 1'h1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Storage array.
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[st_ff.wp] <= port.push_data;
        end
    end
endmodule : data_fifo

// ==== fifo_if.sv ====
// Carrier between the bus unit and its write-data FIFO.
interface fifo_if #(
    parameter int W  = 64,
    parameter int CW = 6
);
    logic          push_valid;
    logic          push_ready;
    logic [W-1:0]  push_data;
    logic          pop_valid;
    logic          pop_ready;
    logic [W-1:0]  pop_data;
    logic [CW-1:0] count;

    modport user  (output push_valid, push_data, pop_ready,
                   input  push_ready, pop_valid, pop_data, count);
    modport store (input  push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data, count);
endinterface : fifo_if

// ==== test_processor_system_bus_interface.sv ====
// Bus unit bench.
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
$display("BAD %s exp %0h got %0h", n, e, g); end end
module test_processor_system_bus_interface
    import bus_unit_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'h0, rst_n_in = 1'h0, req_valid_in = 1'h0, req_ci_in = 1'h0;
    logic req_wt_in = 1'h0, wr_valid_in = 1'h0, rsrv_set_in = 1'h0, drive_size_in = 1'h0;
    logic req_ready_out, wr_ready_out, rd_valid_out, done_out, abr_n_out, dbr_n_out, ci_n_out;
    logic memory_transfer_start_n_out, io_transfer_start_n_out, tbst_n_out, wt_n_out;
    logic data_oe_out, data_par_err_n_out, rsrv_out, drive_size_out, artry_n_in = 1'h1;
    logic abg_n_in, aack_n_in, dbg_n_in, ta_n_in, dretry_n_in, slow = 1'h0, retry = 1'h0;
    logic bad = 1'h0, pm = 1'h1, pi = 1'h1, pp = 1'h1;
    cmd_t req_cmd_in = CMD_READ;
    logic [2:0] req_bytes_in = 3'h0, ttype_out, tsize_out;
    logic [31:0] req_addr_in = 32'h0, addr_out;
    logic [3:0] addr_par_out;
    logic [7:0] data_par_out, data_par_in;
    logic [63:0] wr_data_in = 64'h0, rd_data_out, data_out, data_in, fw, lw;
    logic [40:0] atr;
    int bad_count, n_compared, n_mts, n_ios, n_rd, n_dn, n_pe, n_oe;

    bus_unit u_dut (.ref_clk_in, .rst_n_in, .req_valid_in, .req_cmd_in, .req_addr_in,
        .req_bytes_in, .req_ci_in, .req_wt_in, .req_ready_out, .wr_valid_in, .wr_data_in,
        .wr_ready_out, .rd_valid_out, .rd_data_out, .done_out, .abr_n_out, .abg_n_in,
        .memory_transfer_start_n_out, .io_transfer_start_n_out, .addr_out, .addr_par_out,
        .ttype_out, .tsize_out, .tbst_n_out, .wt_n_out, .ci_n_out, .aack_n_in, .artry_n_in,
        .dbr_n_out, .dbg_n_in, .data_out, .data_oe_out, .data_in, .data_par_out,
        .data_par_in, .data_par_err_n_out, .ta_n_in, .dretry_n_in, .rsrv_set_in,
        .drive_size_in, .rsrv_out, .drive_size_out);
    bus_partner u_far (.ref_clk_in, .abr_n_in(abr_n_out), .dbr_n_in(dbr_n_out), .slow_in(slow),
        .retry_in(retry), .bad_par_in(bad), .abg_n_out(abg_n_in), .dbg_n_out(dbg_n_in),
        .aack_n_out(aack_n_in), .ta_n_out(ta_n_in), .dretry_n_out(dretry_n_in),
        .data_out(data_in), .par_out(data_par_in));

    initial forever #10 ref_clk_in = ~ref_clk_in;

    // Tallies bus events mid-cycle, clear of the launching edge.
    always @(negedge ref_clk_in) begin
        if (pm && !memory_transfer_start_n_out || pi && !io_transfer_start_n_out) begin
            atr = {addr_out, ttype_out, tsize_out, tbst_n_out, wt_n_out, ci_n_out};
        end
        n_mts += pm & !memory_transfer_start_n_out;
        n_ios += pi & !io_transfer_start_n_out;
        n_pe += pp & !data_par_err_n_out;
        n_rd += rd_valid_out;
        n_dn += done_out;
        {pm, pi, pp} = {memory_transfer_start_n_out, io_transfer_start_n_out, data_par_err_n_out};
        if (data_oe_out) begin
            fw = (n_oe == 0) ? data_out : fw;
            lw = data_out;
            n_oe++;
        end
    end

    function automatic logic [19:0] ev();
        return {n_mts[3:0], n_ios[3:0], n_rd[3:0], n_dn[3:0], n_pe[3:0]};
    endfunction : ev

    // Issues one request.
    task automatic xact(input cmd_t c, input logic [31:0] a, input logic [2:0] b,
                        input logic ci, input logic wt);
        {n_mts, n_ios, n_rd, n_dn, n_pe, n_oe} = '0;
        @(negedge ref_clk_in);
        req_cmd_in = c;
        {req_valid_in, req_addr_in, req_bytes_in, req_ci_in, req_wt_in} = {1'h1, a, b, ci, wt};
        while (req_ready_out !== 1'h1) @(negedge ref_clk_in);
        @(negedge ref_clk_in);
        req_valid_in = 1'h0;
        for (int i = 0; i < 90 && n_dn == 0; i++) @(posedge ref_clk_in);
        repeat (8) @(negedge ref_clk_in);
    endtask : xact

    task automatic push(input logic [63:0] w);
        @(negedge ref_clk_in);
        {wr_valid_in, wr_data_in} = {1'h1, w};
        while (wr_ready_out !== 1'h1) @(negedge ref_clk_in);
        @(negedge ref_clk_in);
        wr_valid_in = 1'h0;
    endtask : push

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // Scenarios run in order.
    initial begin
        repeat (12) @(negedge ref_clk_in);
        rst_n_in = 1'h1;
        {rsrv_set_in, drive_size_in} = 2'h3;
        repeat (3) @(negedge ref_clk_in);
        `CHK("idle", 7'h7F, {abr_n_out, dbr_n_out, pm, pi, pp, ~data_oe_out, wr_ready_out})
        `CHK("state", 2'h3, {rsrv_out, drive_size_out})
        xact(CMD_READ, 32'h0000_1003, 3'h3, 1'h1, 1'h0);
        `CHK("read", {32'h0000_1003, 3'h0, 3'h3, 3'h6, 20'h10110}, {atr, ev()})
        slow = 1'h1;
        fork
            xact(CMD_FILL, 32'h0000_1234, 3'h0, 1'h0, 1'h0);
            begin
                repeat (20) @(negedge ref_clk_in);
                `CHK("ungranted", 32'h0, n_mts)
                slow = 1'h0;
            end
        join
        `CHK("fill", {32'h0000_1220, 3'h2, 3'h7, 3'h3, 20'h10410}, {atr, ev()})
        xact(CMD_INVAL, 32'h0000_2000, 3'h0, 1'h0, 1'h0);
        `CHK("inval", {3'h4, 20'h10000, 32'h0}, {atr[8:6], ev(), n_oe})
        xact(CMD_IO, 32'h0000_3000, 3'h0, 1'h0, 1'h0);
        `CHK("io", 20'h01000, ev())
        for (logic [3:0] k = 4'h1; k < 4'h5; k++) push({16{k}});
        xact(CMD_CASTOUT, 32'h0000_0048, 3'h0, 1'h0, 1'h0);
        `CHK("cast", {{16{4'h1}}, {16{4'h4}}, 3'h3, 20'h10010}, {fw, lw, atr[2:0], ev()})
        push(64'hA5A5_0F0F_3C3C_9696);
        retry = 1'h1;
        fork
            xact(CMD_WRITE, 32'h0000_0010, 3'h7, 1'h0, 1'h1);
            begin
                repeat (30) @(negedge ref_clk_in);
                `CHK("held", 32'h0, n_dn)
                retry = 1'h0;
            end
        join
        `CHK("write", {64'hA5A5_0F0F_3C3C_9696, 3'h5, 20'h10010}, {lw, atr[2:0], ev()})
        bad = 1'h1;
        xact(CMD_READ, 32'h0000_0004, 3'h7, 1'h1, 1'h0);
        bad = 1'h0;
        `CHK("parity", 20'h10111, ev())
        $display("tests over");
        close_out;
    end

    initial begin
        #200us;
        bad_count++;
        close_out;
    end
endmodule : test_processor_system_bus_interface
